/* cnbt_pkg.sv */
package cnbt_pkg;

	// ---------------------------------------------------------------
	// Clock and time units
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_NOM_PRESC  = 8'h04;
	localparam logic [7:0] OFS_SEGMENTS   = 8'h08;
	localparam logic [7:0] OFS_DATA_PRESC = 8'h0C;
	localparam logic [7:0] OFS_TX_TIMEOUT = 8'h10;
	localparam logic [7:0] OFS_STATUS     = 8'h14;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTRL_CUSTOM_BIT = 0;
	localparam int SEG_SJW_LSB     = 0;
	localparam int SEG_TS1_LSB     = 8;
	localparam int SEG_TS2_LSB     = 16;
	localparam int ST_DATA_BIT     = 0;
	localparam int ST_BUSY_BIT     = 1;
	localparam int ST_ERR_BIT      = 2;
	localparam int ST_REJ_BIT      = 3;

	// ---------------------------------------------------------------
	// Prescaler limits and reset values
	// ---------------------------------------------------------------
	localparam logic [13:0] PRESC_STEP_NS = 14'h0019;
	localparam logic [13:0] PRESC_MAX_NS  = 14'h3200;
	localparam logic [13:0] DEF_PRESC_NS  = 14'h0032;
	localparam logic [6:0]  DEF_SJW       = 7'h04;
	localparam logic [7:0]  DEF_TS1       = 8'h21;
	localparam logic [6:0]  DEF_TS2       = 7'h04;
	localparam logic [31:0] TIMEOUT_FOREVER = 32'hFFFF_FFFF;
	localparam logic [31:0] DEF_TIMEOUT   = 32'hFFFF_FFFF;

	typedef enum logic [0:0] {TX_IDLE, TX_WAIT} cnbt_tx_e;

endpackage : cnbt_pkg

/* cnbt_tq_gen.sv */
`timescale 1ns/1ps
module cnbt_tq_gen #(
	parameter int W = 10
) (
	input  wire logic         ref_clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] div_in,
	output logic              tick_out
);
	if (W < 2)
	begin : g_bad_w
		$error("cnbt_tq_gen: W too small");
	end

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	wire          wrap = (cnt_q >= div_in - W'(1));

	assign cnt_d = wrap ? '0 : cnt_q + W'(1);

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt_q    <= '0;
			tick_out <= 1'b0;
		end
		else
		begin
			cnt_q    <= cnt_d;
			tick_out <= wrap;
		end
	end

	a_tick_spacing: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		tick_out && div_in == W'(2) && $stable(div_in) |=> !tick_out)
		else $error("tq tick came too early");

endmodule : cnbt_tq_gen

/* cnbt_bit_timing.sv */
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module cnbt_bit_timing #(
	parameter int MS_CYCLES = cnbt_pkg::MS_CYCLES
) (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,
	input  wire logic        rx_in,
	input  wire logic        brs_phase_in,
	input  wire logic        tx_req_in,
	input  wire logic        tx_accept_in,
	output logic             bit_start_out,
	output logic             sample_out,
	output logic             sample_bit_out,
	output logic             tx_busy_out,
	output logic             tx_done_out,
	output logic             tx_err_out
);
	if (MS_CYCLES < 1)
	begin : g_bad_ms
		$error("cnbt_bit_timing: MS_CYCLES must be positive");
	end

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	logic        custom_q;
	logic [13:0] nom_ns_q;
	logic [13:0] data_ns_q;
	logic [6:0]  sjw_q;
	logic [7:0]  ts1_q;
	logic [6:0]  ts2_q;
	logic [31:0] timeout_q;
	logic        rej_q;
	logic [31:0] rmux;

	wire sel_ctrl  = addr_in == cnbt_pkg::OFS_CTRL;
	wire sel_nom   = addr_in == cnbt_pkg::OFS_NOM_PRESC;
	wire sel_seg   = addr_in == cnbt_pkg::OFS_SEGMENTS;
	wire sel_data  = addr_in == cnbt_pkg::OFS_DATA_PRESC;
	wire sel_tmo   = addr_in == cnbt_pkg::OFS_TX_TIMEOUT;
	wire sel_stat  = addr_in == cnbt_pkg::OFS_STATUS;
	wire [13:0] w_ns     = wdata_in[13:0];
	wire [7:0]  w_ts1    = wdata_in[cnbt_pkg::SEG_TS1_LSB +: 8];
	wire        ns_ok    = wdata_in[31:14] == '0 && w_ns >= cnbt_pkg::PRESC_STEP_NS
		&& w_ns <= cnbt_pkg::PRESC_MAX_NS && (w_ns % cnbt_pkg::PRESC_STEP_NS) == '0;
	wire        seg_ok   = w_ts1 != 8'h00;
	wire        wr_nom   = wr_in && sel_nom && ns_ok;
	wire        wr_data  = wr_in && sel_data && ns_ok;
	wire        wr_seg   = wr_in && sel_seg && seg_ok;
	wire        rej_set  = wr_in && (((sel_nom || sel_data) && !ns_ok) || (sel_seg && !seg_ok));
	wire        rej_clr  = wr_in && sel_stat && wdata_in[cnbt_pkg::ST_REJ_BIT];

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			custom_q  <= 1'b0;
			nom_ns_q  <= cnbt_pkg::DEF_PRESC_NS;
			data_ns_q <= cnbt_pkg::DEF_PRESC_NS;
			sjw_q     <= cnbt_pkg::DEF_SJW;
			ts1_q     <= cnbt_pkg::DEF_TS1;
			ts2_q     <= cnbt_pkg::DEF_TS2;
			timeout_q <= cnbt_pkg::DEF_TIMEOUT;
			rej_q     <= 1'b0;
			rdata_out <= '0;
		end
		else
		begin
			if (wr_in && sel_ctrl) custom_q <= wdata_in[cnbt_pkg::CTRL_CUSTOM_BIT];
			if (wr_nom) nom_ns_q <= w_ns;
			if (wr_data) data_ns_q <= w_ns;
			if (wr_seg)
			begin
				sjw_q <= wdata_in[cnbt_pkg::SEG_SJW_LSB +: 7];
				ts1_q <= w_ts1;
				ts2_q <= wdata_in[cnbt_pkg::SEG_TS2_LSB +: 7];
			end
			if (wr_in && sel_tmo) timeout_q <= wdata_in;
			// Set wins over clear
			rej_q     <= rej_set | (rej_q & ~rej_clr);
			rdata_out <= rd_in ? rmux : '0;
		end
	end

	always_comb
	begin
		rmux = '0;
		if (sel_ctrl) rmux[cnbt_pkg::CTRL_CUSTOM_BIT] = custom_q;
		if (sel_nom) rmux[13:0] = nom_ns_q;
		if (sel_data) rmux[13:0] = data_ns_q;
		if (sel_seg)
		begin
			rmux[cnbt_pkg::SEG_SJW_LSB +: 7] = sjw_q;
			rmux[cnbt_pkg::SEG_TS1_LSB +: 8] = ts1_q;
			rmux[cnbt_pkg::SEG_TS2_LSB +: 7] = ts2_q;
		end
		if (sel_tmo) rmux = timeout_q;
		if (sel_stat)
		begin
			rmux[cnbt_pkg::ST_DATA_BIT] = brs_phase_in;
			rmux[cnbt_pkg::ST_BUSY_BIT] = tx_busy_out;
			rmux[cnbt_pkg::ST_ERR_BIT]  = tx_err_out;
			rmux[cnbt_pkg::ST_REJ_BIT]  = rej_q;
		end
	end

	// ---------------------------------------------------------------
	// Effective timing values
	// ---------------------------------------------------------------
	// default nominal prescaler unless customised; data phase always uses the data prescaler
	wire [13:0] nom_eff_ns = custom_q ? nom_ns_q : cnbt_pkg::DEF_PRESC_NS;
	wire [13:0] eff_ns     = brs_phase_in ? data_ns_q : nom_eff_ns;
	wire [13:0] div_wide   = eff_ns / cnbt_pkg::PRESC_STEP_NS;
	wire [9:0]  tq_div     = div_wide[9:0];
	// plus one quantum, defaults unless customised
	wire [9:0]  sjw_eff    = 10'(custom_q ? sjw_q : cnbt_pkg::DEF_SJW) + 10'd1;
	wire [9:0]  ts1_eff    = 10'(custom_q ? ts1_q : cnbt_pkg::DEF_TS1) + 10'd1;
	wire [9:0]  ts2_eff    = 10'(custom_q ? ts2_q : cnbt_pkg::DEF_TS2) + 10'd1;
	wire        tick;

	cnbt_tq_gen #(.W(10)) u_tq (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.div_in     (tq_div),
		.tick_out   (tick)
	);

	// ---------------------------------------------------------------
	// Bit segment counter with resynchronisation
	// ---------------------------------------------------------------
	logic [9:0] idx_q;
	logic [9:0] ext_q;
	logic [9:0] shr_q;
	logic       synced_q;
	logic       rx_tq_q;
	logic [9:0] ext_d;
	logic [9:0] shr_d;
	logic       restart;

	wire [9:0] idx_inc  = idx_q + 10'd1;
	wire       edge_det = tick && rx_tq_q && !rx_in && !synced_q && idx_q != '0;
	// boundary after sync quantum and first segment
	wire [9:0] seg1_end = 10'd1 + ts1_eff + ext_d;
	wire [9:0] bit_end  = seg1_end + ts2_eff - shr_d;
	wire [9:0] remain   = bit_end - idx_q;

	// phase error limited by jump width
	always_comb
	begin
		ext_d   = ext_q;
		shr_d   = shr_q;
		restart = 1'b0;
		if (edge_det)
		begin
			if (idx_q < 10'd1 + ts1_eff + ext_q)
				ext_d = (idx_q < sjw_eff) ? idx_q : sjw_eff;
			else if (10'd1 + ts1_eff + ext_q + ts2_eff - shr_q - idx_q <= sjw_eff)
				restart = 1'b1;
			else
				shr_d = sjw_eff;
		end
	end

	// Ends at once if new settings fall behind the count
	wire bit_hit = tick && (restart || idx_inc >= bit_end);
	wire smp_hit = tick && !restart && idx_inc == seg1_end;

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			idx_q          <= '0;
			ext_q          <= '0;
			shr_q          <= '0;
			synced_q       <= 1'b0;
			rx_tq_q        <= 1'b1;
			bit_start_out  <= 1'b0;
			sample_out     <= 1'b0;
			sample_bit_out <= 1'b1;
		end
		else
		begin
			if (tick) rx_tq_q <= rx_in;
			idx_q         <= bit_hit ? '0 : (tick ? idx_inc : idx_q);
			ext_q         <= bit_hit ? '0 : ext_d;
			shr_q         <= bit_hit ? '0 : shr_d;
			synced_q      <= bit_hit ? 1'b0 : (synced_q | edge_det);
			bit_start_out <= bit_hit;
			sample_out    <= smp_hit;
			if (smp_hit) sample_bit_out <= rx_in;
		end
	end

	// ---------------------------------------------------------------
	// Transmit submission with timeout
	// ---------------------------------------------------------------
	cnbt_pkg::cnbt_tx_e tx_st_q;
	logic [31:0] ms_q;
	logic [31:0] cyc_q;

	wire forever_wait = timeout_q == cnbt_pkg::TIMEOUT_FOREVER;
	wire ms_wrap      = cyc_q == 32'(MS_CYCLES - 1);
	// expiry only with a finite timeout
	wire expired      = !forever_wait && ms_q >= timeout_q;
	wire in_wait      = tx_st_q == cnbt_pkg::TX_WAIT;
	wire tx_ok        = in_wait && tx_accept_in;
	wire tx_fail      = in_wait && !tx_accept_in && expired;

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			tx_st_q     <= cnbt_pkg::TX_IDLE;
			ms_q        <= '0;
			cyc_q       <= '0;
			tx_busy_out <= 1'b0;
			tx_done_out <= 1'b0;
			tx_err_out  <= 1'b0;
		end
		else
		begin
			tx_done_out <= tx_ok | tx_fail;
			case (tx_st_q)
				cnbt_pkg::TX_IDLE:
				begin
					ms_q  <= '0;
					cyc_q <= '0;
					if (tx_req_in)
					begin
						tx_st_q     <= cnbt_pkg::TX_WAIT;
						tx_busy_out <= 1'b1;
					end
				end
				cnbt_pkg::TX_WAIT:
				begin
					cyc_q <= ms_wrap ? '0 : cyc_q + 32'd1;
					if (ms_wrap && !forever_wait) ms_q <= ms_q + 32'd1;
					if (tx_ok || tx_fail)
					begin
						tx_st_q     <= cnbt_pkg::TX_IDLE;
						tx_busy_out <= 1'b0;
						tx_err_out  <= tx_fail;
					end
				end
				default: tx_st_q <= cnbt_pkg::TX_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	logic [19:0] since_bit_q;
	logic        clean_q;
	wire         dflt = !custom_q && !brs_phase_in;

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			since_bit_q <= '0;
			clean_q     <= 1'b0;
		end
		else
		begin
			since_bit_q <= bit_start_out ? '0 : since_bit_q + 20'd1;
			clean_q     <= bit_start_out ? (!edge_det & dflt) : (clean_q & !edge_det & dflt);
		end
	end


	a_default_presc: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!custom_q && !brs_phase_in |-> tq_div == 10'd2)
		else $error("default prescaler is not two cycles");
	a_bad_presc_kept: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		wr_in && sel_nom && !ns_ok |=> $stable(nom_ns_q) && rej_q)
		else $error("invalid prescaler was taken");
	a_sjw_bound: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ext_q <= sjw_eff && shr_q <= sjw_eff)
		else $error("resync exceeds jump width");
	a_ts1_nonzero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		wr_in && sel_seg && w_ts1 == 8'h00 |=> $stable(ts1_q))
		else $error("zero first segment was taken");
	a_seg2_length: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		bit_start_out && dflt && clean_q |-> $past(sample_out, 10))
		else $error("second segment length wrong");
	a_default_bit: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		bit_start_out && dflt && clean_q |-> since_bit_q == 20'd79)
		else $error("default bit is not 80 cycles");
	a_default_sample: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		sample_out && dflt && clean_q |-> since_bit_q == 20'd69)
		else $error("default sample point not at 87.5 percent");
	a_data_rate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		brs_phase_in |-> 14'(tq_div) * cnbt_pkg::PRESC_STEP_NS == data_ns_q)
		else $error("data phase not on data prescaler");
	a_forever_wait: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		in_wait && forever_wait && !tx_accept_in |=> !tx_done_out && tx_busy_out)
		else $error("infinite timeout ended submission");
	a_fail_reported: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		tx_done_out |-> tx_err_out == !$past(tx_accept_in))
		else $error("submission result misreported");
	a_sample_inside: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		sample_out |-> !bit_start_out)
		else $error("sample on a bit boundary");

	c_resync: cover property (@(posedge ref_clk_in) disable iff (rst_in) edge_det);
	c_restart: cover property (@(posedge ref_clk_in) disable iff (rst_in) restart);
	c_tx_fail: cover property (@(posedge ref_clk_in) disable iff (rst_in) tx_fail);
	c_data_bit: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		brs_phase_in && bit_start_out);

endmodule : cnbt_bit_timing

/* cnbt_bus_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bus level seen through the transceiver
// ---------------------------------------------------------------
module cnbt_bus_model (
	input  wire logic ref_clk_in,
	input  wire logic dom_req_in,
	output logic      rx_out
);
	logic level_q = 1'b1;

	assign rx_out = level_q;
	// Recessive unless some node pulls the line dominant
	always @(posedge ref_clk_in)
	begin
		level_q <= ~dom_req_in;
	end
endmodule : cnbt_bus_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
	logic        ref_clk_in   = 1'b0;
	logic        rst_in       = 1'b1;
	logic [7:0]  addr_in      = 8'h00;
	logic [31:0] wdata_in     = 32'h0000_0000;
	logic        wr_in        = 1'b0;
	logic        rd_in        = 1'b0;
	logic        brs_phase_in = 1'b0;
	logic        tx_req_in    = 1'b0;
	logic        tx_accept_in = 1'b0;
	logic        dom_req      = 1'b0;
	logic        rx_in;
	logic [31:0] rdata_out;
	logic        bit_start_out;
	logic        sample_out;
	logic        sample_bit_out;
	logic        tx_busy_out;
	logic        tx_done_out;
	logic        tx_err_out;
	int          n_fail       = 0;
	int          cmp_count    = 0;
	int          d_s;
	int          d_b;
	int          n;

	cnbt_bit_timing #(.MS_CYCLES(4)) u_dut (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.rx_in(rx_in), .brs_phase_in(brs_phase_in), .tx_req_in(tx_req_in),
		.tx_accept_in(tx_accept_in), .bit_start_out(bit_start_out),
		.sample_out(sample_out), .sample_bit_out(sample_bit_out),
		.tx_busy_out(tx_busy_out), .tx_done_out(tx_done_out), .tx_err_out(tx_err_out)
	);
	cnbt_bus_model u_bus (.ref_clk_in(ref_clk_in), .dom_req_in(dom_req), .rx_out(rx_in));

	initial
	begin
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end

	// ---------------------------------------------------------------
	// Access and compare tasks
	// ---------------------------------------------------------------
	task final_report;
		if (n_fail == 0 && cmp_count > 0)
		begin
			$display("*** PASS ***");
		end
		else
		begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge ref_clk_in);
		rd_in <= 1'b0;
		@(negedge ref_clk_in);
		chk(rdata_out, e);
	endtask : rd

	task pulse_tx(input logic acc);
		@(posedge ref_clk_in);
		if (acc) tx_accept_in <= 1'b1;
		else tx_req_in <= 1'b1;
		@(posedge ref_clk_in);
		tx_accept_in <= 1'b0;
		tx_req_in <= 1'b0;
	endtask : pulse_tx

	// Cycles from bit start to sample point and to next bit start
	task meas(output int s, output int b);
		int k;
		k = 0;
		s = 0;
		b = 0;
		do
		begin
			@(negedge ref_clk_in);
			k++;
		end while (bit_start_out !== 1'b1 && k < 3000);
		do
		begin
			@(negedge ref_clk_in);
			b++;
			if (sample_out === 1'b1) s = b;
		end while (bit_start_out !== 1'b1 && b < 3000);
	endtask : meas

	task tx_wait(output int c);
		c = 0;
		do
		begin
			@(negedge ref_clk_in);
			c++;
		end while (tx_done_out !== 1'b1 && c < 400);
	endtask : tx_wait

	initial
	begin
		repeat (30000) @(posedge ref_clk_in);
		n_fail++;
		final_report();
	end

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rd(cnbt_pkg::OFS_CTRL, 32'h0000_0000);
		rd(cnbt_pkg::OFS_NOM_PRESC, {18'h0_0000, cnbt_pkg::DEF_PRESC_NS});
		rd(cnbt_pkg::OFS_SEGMENTS, {9'h000, cnbt_pkg::DEF_TS2, cnbt_pkg::DEF_TS1, 1'b0,
			cnbt_pkg::DEF_SJW});
		rd(cnbt_pkg::OFS_DATA_PRESC, {18'h0_0000, cnbt_pkg::DEF_PRESC_NS});
		rd(cnbt_pkg::OFS_TX_TIMEOUT, 32'hFFFF_FFFF);
		rd(cnbt_pkg::OFS_STATUS, 32'h0000_0000);
		rd(8'h18, 32'h0000_0000);
		meas(d_s, d_b);
		chk(d_s, 32'h0000_0046);
		chk(d_b, 32'h0000_0050);
		@(posedge ref_clk_in);
		dom_req <= 1'b1;
		meas(d_s, d_b);
		chk({31'h0, sample_bit_out}, 32'h0000_0000);
		@(posedge ref_clk_in);
		dom_req <= 1'b0;
		meas(d_s, d_b);
		meas(d_s, d_b);
		chk({31'h0, sample_bit_out}, 32'h0000_0001);
		wr(cnbt_pkg::OFS_CTRL, 32'h0000_0001);
		wr(cnbt_pkg::OFS_NOM_PRESC, 32'h0000_0019);
		wr(cnbt_pkg::OFS_SEGMENTS, 32'h0002_0501);
		meas(d_s, d_b);
		meas(d_s, d_b);
		chk(d_s, 32'h0000_0007);
		chk(d_b, 32'h0000_000A);
		@(posedge ref_clk_in);
		brs_phase_in <= 1'b1;
		wr(cnbt_pkg::OFS_DATA_PRESC, 32'h0000_0064);
		rd(cnbt_pkg::OFS_STATUS, 32'h0000_0001);
		meas(d_s, d_b);
		meas(d_s, d_b);
		chk(d_s, 32'h0000_001C);
		chk(d_b, 32'h0000_0028);
		@(posedge ref_clk_in);
		brs_phase_in <= 1'b0;
		wr(cnbt_pkg::OFS_NOM_PRESC, 32'h0000_001E);
		rd(cnbt_pkg::OFS_STATUS, 32'h0000_0008);
		wr(cnbt_pkg::OFS_STATUS, 32'h0000_0008);
		rd(cnbt_pkg::OFS_STATUS, 32'h0000_0000);
		wr(cnbt_pkg::OFS_NOM_PRESC, 32'h0000_3219);
		wr(cnbt_pkg::OFS_SEGMENTS, 32'h0002_0001);
		rd(cnbt_pkg::OFS_NOM_PRESC, 32'h0000_0019);
		rd(cnbt_pkg::OFS_SEGMENTS, 32'h0002_0501);
		wr(cnbt_pkg::OFS_NOM_PRESC, 32'h0000_3200);
		rd(cnbt_pkg::OFS_NOM_PRESC, 32'h0000_3200);
		wr(cnbt_pkg::OFS_SEGMENTS, 32'h007F_FF7F);
		rd(cnbt_pkg::OFS_SEGMENTS, 32'h007F_FF7F);
		wr(cnbt_pkg::OFS_CTRL, 32'h0000_0000);
		meas(d_s, d_b);
		meas(d_s, d_b);
		chk(d_b, 32'h0000_0050);
		pulse_tx(1'b0);
		repeat (300) @(negedge ref_clk_in);
		chk({31'h0, tx_busy_out}, 32'h0000_0001);
		rd(cnbt_pkg::OFS_STATUS, 32'h0000_000A);
		pulse_tx(1'b1);
		tx_wait(n);
		chk(n, 32'h0000_0001);
		chk({31'h0, tx_err_out}, 32'h0000_0000);
		wr(cnbt_pkg::OFS_TX_TIMEOUT, 32'h0000_0002);
		pulse_tx(1'b0);
		tx_wait(n);
		chk({31'h0, n >= 8 && n <= 11}, 32'h0000_0001);
		chk({31'h0, tx_err_out}, 32'h0000_0001);
		wr(cnbt_pkg::OFS_TX_TIMEOUT, 32'h0000_0000);
		pulse_tx(1'b0);
		tx_wait(n);
		chk({31'h0, n <= 3}, 32'h0000_0001);
		chk({31'h0, tx_err_out}, 32'h0000_0001);
		rd(cnbt_pkg::OFS_STATUS, 32'h0000_000C);
		final_report();
	end
endmodule : tb
